// File: inc/jbst_regs.vh
`ifndef JBST_REGS_VH
`define JBST_REGS_VH
// instruction codes, five bits
`define JBST_IR_W 5
`define JBST_OP_EXTEST 5'h00
`define JBST_OP_SAMPLE 5'h01
`define JBST_OP_CLAMP 5'h04
`define JBST_OP_HIGHZ 5'h05
`define JBST_OP_IDCODE 5'h0c
`define JBST_OP_BYPASS 5'h1f
// identification register fields
`define JBST_ID_VER_MSB 31
`define JBST_ID_VER_LSB 28
`define JBST_ID_PART_MSB 27
`define JBST_ID_PART_LSB 12
`define JBST_ID_MFR_MSB 11
`define JBST_ID_MFR_LSB 1
// tap states, binary coded
`define JBST_S_TLR 4'h0
`define JBST_S_RTI 4'h1
`define JBST_S_SDR 4'h2
`define JBST_S_CDR 4'h3
`define JBST_S_SHDR 4'h4
`define JBST_S_E1DR 4'h5
`define JBST_S_PDR 4'h6
`define JBST_S_E2DR 4'h7
`define JBST_S_UDR 4'h8
`define JBST_S_SIR 4'h9
`define JBST_S_CIR 4'ha
`define JBST_S_SHIR 4'hb
`define JBST_S_E1IR 4'hc
`define JBST_S_PIR 4'hd
`define JBST_S_E2IR 4'he
`define JBST_S_UIR 4'hf
// power-on reset stretch, in ref_clk cycles
`define JBST_POR_CYC 8'h10
`endif

// File: rtl/jbst_bscell.v
`timescale 1ns/100ps
`include "jbst_regs.vh"
// one boundary scan cell: capture/shift stage plus update stage
module jbst_bscell (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// tck event enables
	input wire rise_en,
	// control from tap
	input wire capture,
	input wire shift,
	input wire update,
	// serial path
	input wire scan_in,
	output wire scan_out,
	// parallel path
	input wire pin_val,
	output wire upd_val
);
	reg cap_ff; // master stage
	reg upd_ff; // update stage
	// master loads in parallel or shifts on tck rise
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cap_ff <= 1'b0;
		end else if (rise_en && capture) begin
			cap_ff <= pin_val;
		end else if (rise_en && shift) begin
			cap_ff <= scan_in;
		end
	end
	// update stage; loads on the falling-tck pulse inside update-dr, so pins move only then
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			upd_ff <= 1'b0;
		end else if (update) begin
			upd_ff <= cap_ff;
		end
	end
	assign scan_out = cap_ff;
	assign upd_val = upd_ff;
endmodule // jbst_bscell

// File: rtl/jbst_tap.v
`timescale 1ns/100ps
`include "jbst_regs.vh"
module jbst_tap #(
	parameter N_IN = 3, // input-only pins
	parameter N_OUT = 4, // output-only pins
	parameter N_BIDIR = 4, // bidirectional pins
	parameter N_CTL = 2, // output enable control cells
	parameter [3:0] ID_VER = 4'h1, // arbitrary value
	parameter [15:0] ID_PART = 16'h1234, // arbitrary value
	parameter [10:0] ID_MFR = 11'h2aa // arbitrary value
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// test access pins
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	output wire tdo,
	output wire tdo_oe_n,
	// core side of input pins
	input wire [N_IN-1:0] in_pad,
	output wire [N_IN-1:0] in_core,
	// core side of output pins
	input wire [N_OUT-1:0] out_core,
	output wire [N_OUT-1:0] out_pad,
	output wire out_pad_oe_n,
	// core side of bidir pins, one enable per control group
	input wire [N_BIDIR-1:0] bd_pad_in,
	input wire [N_BIDIR-1:0] bd_core_out,
	input wire [N_CTL-1:0] bd_core_oe_n,
	output wire [N_BIDIR-1:0] bd_core_in,
	output wire [N_BIDIR-1:0] bd_pad_out,
	output wire [N_BIDIR-1:0] bd_pad_oe_n
);
	localparam BS_LEN = N_IN + N_OUT + 2 * N_BIDIR + N_CTL;
	localparam ID_W = 32;
	// chain length follows the pin mix: one cell per input or output pin,
	// two per bidir pin (pad side and core side), one per enable group
	// tap pins are never counted, they run the chain rather than join it
	// synchronisers for pins from the tester's domain
	// all four pins pass the same two stages, so tms and tdi are seen
	// with exactly the tck sample they were set up for
	// the tester keeps each tck phase several ref_clk long, which this
	// depends on: a tck faster than about half of ref_clk loses edges
	reg [3:0] s1_ff; // first stage only read by s2_ff
	reg [3:0] s2_ff; // tck, tms, tdi, trst_n
	reg tck_d_ff; // previous sampled tck for edge finding
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
			tck_d_ff <= 1'b0;
		end else begin
			s1_ff <= {tck, tms, tdi, trst_n};
			s2_ff <= s1_ff;
			tck_d_ff <= s2_ff[3];
		end
	end
	wire tck_s = s2_ff[3];
	wire tms_s = s2_ff[2];
	wire tdi_s = s2_ff[1];
	wire trst_s_n = s2_ff[0];
	wire rise_en = tck_s & ~tck_d_ff; // one-cycle pulse on tck rise
	wire fall_en = ~tck_s & tck_d_ff; // one-cycle pulse on tck fall
	// both pulses last one ref_clk, so each tck edge acts exactly once
	// the edge detector resets low, matching the idle level of tck,
	// so no false rise follows reset
	// power-on reset stretch, cleared and restarted by the system reset nrst
	// the counter holds the controller in test-logic-reset for a fixed span
	// after nrst lifts, long enough for the synchronisers to fill with real
	// pin values before any tck edge can move the state
	// it stops at its end value, so it never wraps back into reset
	reg [7:0] por_cnt_ff;
	wire por_act = (por_cnt_ff != `JBST_POR_CYC);
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			por_cnt_ff <= 8'h00;
		end else if (por_act) begin
			por_cnt_ff <= por_cnt_ff + 8'h01;
		end
	end
	// tap state register
	reg [3:0] st_ff;
	reg [3:0] nxt_st;
	// next-state table of the sixteen states
	// data-register column on the lower codes, instruction column on the
	// upper ones; every four-bit code is listed, and the default only
	// guards against an unknown state, landing in test-logic-reset
	// tms high from any state reaches test-logic-reset within five rises
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			`JBST_S_TLR: nxt_st = tms_s ? `JBST_S_TLR : `JBST_S_RTI;
			`JBST_S_RTI: nxt_st = tms_s ? `JBST_S_SDR : `JBST_S_RTI;
			`JBST_S_SDR: nxt_st = tms_s ? `JBST_S_SIR : `JBST_S_CDR;
			`JBST_S_CDR: nxt_st = tms_s ? `JBST_S_E1DR : `JBST_S_SHDR;
			`JBST_S_SHDR: nxt_st = tms_s ? `JBST_S_E1DR : `JBST_S_SHDR;
			`JBST_S_E1DR: nxt_st = tms_s ? `JBST_S_UDR : `JBST_S_PDR;
			`JBST_S_PDR: nxt_st = tms_s ? `JBST_S_E2DR : `JBST_S_PDR;
			`JBST_S_E2DR: nxt_st = tms_s ? `JBST_S_UDR : `JBST_S_SHDR;
			`JBST_S_UDR: nxt_st = tms_s ? `JBST_S_SDR : `JBST_S_RTI;
			`JBST_S_SIR: nxt_st = tms_s ? `JBST_S_TLR : `JBST_S_CIR;
			`JBST_S_CIR: nxt_st = tms_s ? `JBST_S_E1IR : `JBST_S_SHIR;
			`JBST_S_SHIR: nxt_st = tms_s ? `JBST_S_E1IR : `JBST_S_SHIR;
			`JBST_S_E1IR: nxt_st = tms_s ? `JBST_S_UIR : `JBST_S_PIR;
			`JBST_S_PIR: nxt_st = tms_s ? `JBST_S_E2IR : `JBST_S_PIR;
			`JBST_S_E2IR: nxt_st = tms_s ? `JBST_S_UIR : `JBST_S_SHIR;
			`JBST_S_UIR: nxt_st = tms_s ? `JBST_S_SDR : `JBST_S_RTI;
			default: nxt_st = `JBST_S_TLR;
		endcase
	end
	// state advances only on tck rise; trst and power-on force reset
	// trst is sampled, so it acts two ref_clk late; that is far shorter
	// than one tck phase, so no tck edge can slip past it
	// priority: power-on first, then trst, then the tms walk
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= `JBST_S_TLR;
		end else if (por_act) begin
			st_ff <= `JBST_S_TLR;
		end else if (!trst_s_n) begin
			st_ff <= `JBST_S_TLR;
		end else if (rise_en) begin
			st_ff <= nxt_st;
		end
	end
	wire in_tlr = (st_ff == `JBST_S_TLR);
	wire in_cdr = (st_ff == `JBST_S_CDR);
	wire in_shdr = (st_ff == `JBST_S_SHDR);
	wire in_cir = (st_ff == `JBST_S_CIR);
	wire in_shir = (st_ff == `JBST_S_SHIR);
	// captures and shifts all act on rise_en, updates on fall_en, which
	// keeps the parallel outputs steady during the whole shift
	// update pulses fire on the falling tck inside the update state
	wire upd_dr = fall_en & (st_ff == `JBST_S_UDR);
	wire upd_ir = fall_en & (st_ff == `JBST_S_UIR);
	// both are gated by the state, so a stray fall outside update
	// leaves the hold registers alone
	// instruction shift and hold registers
	// the shift stage captures the fixed pattern and shifts lsb first;
	// the hold stage takes the shift stage only in update-ir, so a half-loaded code
	// never reaches the decode
	// test-logic-reset reloads both, whatever the tester left behind
	reg [`JBST_IR_W-1:0] ir_sh_ff;
	reg [`JBST_IR_W-1:0] ir_ff;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ir_sh_ff <= `JBST_OP_IDCODE;
			ir_ff <= `JBST_OP_IDCODE;
		end else if (in_tlr) begin
			// reset leaves idcode active, as 1149.1 expects with an id register
			ir_ff <= `JBST_OP_IDCODE;
			ir_sh_ff <= `JBST_OP_IDCODE;
		end else begin
			if (rise_en && in_cir) begin
				ir_sh_ff <= 5'h01; // fixed 01 capture pattern
			end else if (rise_en && in_shir) begin
				ir_sh_ff <= {tdi_s, ir_sh_ff[`JBST_IR_W-1:1]};
			end
			if (upd_ir) begin
				ir_ff <= ir_sh_ff;
			end
		end
	end
	// instruction decode; unlisted codes fall through to bypass
	// sel_bs and sel_id pick the data register, drive_cells hands the
	// pins to the update cells, float_all releases every output enable
	// codes reserved for private tests also land in bypass here, since
	// this block carries no internal scan or memory test paths
	reg sel_bs;
	reg sel_id;
	reg drive_cells;
	reg float_all;
	always @* begin
		sel_bs = 1'b0;
		sel_id = 1'b0;
		drive_cells = 1'b0;
		float_all = 1'b0;
		case (ir_ff)
			`JBST_OP_EXTEST: begin
				sel_bs = 1'b1;
				drive_cells = 1'b1;
			end
			`JBST_OP_SAMPLE: begin
				sel_bs = 1'b1;
			end
			`JBST_OP_HIGHZ: begin
				float_all = 1'b1;
			end
			`JBST_OP_CLAMP: begin
				drive_cells = 1'b1;
			end
			`JBST_OP_IDCODE: begin
				sel_id = 1'b1;
			end
			default: begin
				sel_bs = 1'b0;
			end
		endcase
	end
	wire sel_byp = ~sel_bs & ~sel_id;
	// bypass stage, captures zero
	// a capture of zero lets the tester count devices on the board
	// from the leading zeros it reads back
	reg byp_ff;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			byp_ff <= 1'b0;
		end else if (rise_en && in_cdr && sel_byp) begin
			byp_ff <= 1'b0;
		end else if (rise_en && in_shdr && sel_byp) begin
			byp_ff <= tdi_s;
		end
	end
	// identification shift register, loaded from constants on capture
	// the word never changes, so reading it twice gives the same bits;
	// bit 0 is fixed at one to tell it apart from a bypass zero
	wire [ID_W-1:0] id_val = {ID_VER, ID_PART, ID_MFR, 1'b1};
	reg [ID_W-1:0] id_sh_ff;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			id_sh_ff <= {ID_W{1'b0}};
		end else if (rise_en && in_cdr && sel_id) begin
			id_sh_ff <= id_val;
		end else if (rise_en && in_shdr && sel_id) begin
			id_sh_ff <= {tdi_s, id_sh_ff[ID_W-1:1]};
		end
	end
	// parallel values per chain position: inputs, outputs, bidirs, controls
	// only functional pins are listed; tap pins never enter the chain
	// position 0 sits next to tdo, the last position next to tdi
	// bidir pins get a cell for the pad side and one for the core side
	wire [BS_LEN-1:0] par_val;
	wire [BS_LEN-1:0] upd_val;
	wire [BS_LEN:0] chain;
	assign chain[BS_LEN] = tdi_s;
	assign par_val[N_IN-1:0] = in_pad;
	assign par_val[N_IN+N_OUT-1:N_IN] = out_core;
	assign par_val[N_IN+N_OUT+N_BIDIR-1:N_IN+N_OUT] = bd_pad_in;
	assign par_val[N_IN+N_OUT+2*N_BIDIR-1:N_IN+N_OUT+N_BIDIR] = bd_core_out;
	assign par_val[BS_LEN-1:N_IN+N_OUT+2*N_BIDIR] = bd_core_oe_n;
	// chain of dedicated cells, shifting from tdi toward tdo
	// every cell sees the same control strobes; only the selected
	// instruction lets them capture, shift or update
	// cells play no part in normal operation, they only feed the muxes
	genvar gi;
	generate
		for (gi = 0; gi < BS_LEN; gi = gi + 1) begin : g_cell
			jbst_bscell u_cell (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.rise_en(rise_en),
				.capture(in_cdr & sel_bs),
				.shift(in_shdr & sel_bs),
				.update(upd_dr & sel_bs),
				.scan_in(chain[gi+1]),
				.scan_out(chain[gi]),
				.pin_val(par_val[gi]),
				.upd_val(upd_val[gi])
			);
		end
	endgenerate
	// pin muxing: core path unless cells drive; highz floats all outputs
	// inputs always pass straight to the core: sampling must not
	// disturb the system, and extest only needs the captured value
	// output-only pins share one enable, floated only under highz
	// bidir enables come from the control cells while cells drive
	wire [N_CTL-1:0] ctl_cell = upd_val[BS_LEN-1:N_IN+N_OUT+2*N_BIDIR];
	wire [N_CTL-1:0] grp_oe_n = drive_cells ? ctl_cell : bd_core_oe_n;
	assign in_core = in_pad;
	assign out_pad = drive_cells ? upd_val[N_IN+N_OUT-1:N_IN] : out_core;
	assign out_pad_oe_n = float_all;
	assign bd_core_in = bd_pad_in;
	assign bd_pad_out = drive_cells ? upd_val[N_IN+N_OUT+2*N_BIDIR-1:N_IN+N_OUT+N_BIDIR] : bd_core_out;
	// bidir pin i joins group i*N_CTL/N_BIDIR rounded down, so group sizes differ by one pin at most
	// a group enable is active low, so a one in a control cell floats
	// every pin of its group
	generate
		for (gi = 0; gi < N_BIDIR; gi = gi + 1) begin : g_oe
			localparam integer GRP = (gi * N_CTL) / N_BIDIR;
			assign bd_pad_oe_n[gi] = float_all | grp_oe_n[GRP];
		end
	endgenerate
	// tdo source selection
	// the instruction register wins in shift-ir; otherwise the selected
	// data register feeds tdo, bypass being the fallback
	reg tdo_src;
	always @* begin
		tdo_src = byp_ff;
		if (in_shir) begin
			tdo_src = ir_sh_ff[0];
		end else if (sel_bs) begin
			tdo_src = chain[0];
		end else if (sel_id) begin
			tdo_src = id_sh_ff[0];
		end
	end
	// tdo and its enable retimed on falling tck, so the tester reads it at rise
	// the enable falls with the first bit and rises after the last one,
	// so the pin is released in every state that does not shift
	reg tdo_ff;
	reg tdo_oe_n_ff;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tdo_ff <= 1'b0;
			tdo_oe_n_ff <= 1'b1;
		end else if (fall_en) begin
			// tdo holds outside the shift states, so it never moves while released
			if (in_shdr | in_shir) begin
				tdo_ff <= tdo_src;
			end
			tdo_oe_n_ff <= ~(in_shdr | in_shir);
		end
	end
	// tdo is a flop output, so it never glitches between tck edges
	assign tdo = tdo_ff;
	assign tdo_oe_n = tdo_oe_n_ff;
endmodule // jbst_tap

// File: dv/jbst_tap_props.sv
`timescale 1ns/100ps
// watches the tap pins; tck is only data to the system clock
module jbst_tap_props #(
	parameter N_IN = 3,
	parameter N_OUT = 4,
	parameter N_BIDIR = 4
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// test access pins
	input wire tck,
	input wire trst_n,
	input wire tdo,
	input wire tdo_oe_n,
	// functional pins
	input wire [N_IN-1:0] in_pad,
	input wire [N_IN-1:0] in_core,
	input wire [N_OUT-1:0] out_core,
	input wire [N_OUT-1:0] out_pad,
	input wire out_pad_oe_n,
	input wire [N_BIDIR-1:0] bd_core_out,
	input wire [N_BIDIR-1:0] bd_pad_out,
	input wire [N_BIDIR-1:0] bd_pad_oe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// falling tck as the system clock sees it
	sequence s_tck_fall;
		tck ##1 !tck;
	endsequence
	// test reset held past the synchroniser
	sequence s_trst_held;
		!trst_n [*5];
	endsequence
	a_in_core_pass: assert property (in_core == in_pad)
		else $error("input pin not passed to core");
	a_tdo_fall_only: assert property ($changed(tdo) |-> !tck && !$past(tck))
		else $error("tdo moved outside low tck");
	a_oe_fall_only: assert property ($changed(tdo_oe_n) |-> !tck)
		else $error("tdo enable moved while tck high");
	a_tdo_settled: assert property (s_tck_fall ##6 1 |-> $stable(tdo) [*6])
		else $error("tdo not standing until next fall");
	a_tdo_when_driven: assert property ($changed(tdo) |-> !tdo_oe_n || $changed(tdo_oe_n))
		else $error("tdo moved while not driven");
	a_highz_all: assert property (out_pad_oe_n |-> &bd_pad_oe_n)
		else $error("bidir pin driven under float");
	a_por_hold: assert property ($rose(nrst) |-> (tdo_oe_n && !out_pad_oe_n) [*8])
		else $error("tap not idle after power-up");
	a_trst_normal: assert property (s_trst_held |-> !out_pad_oe_n && out_pad == out_core
		&& bd_pad_out == bd_core_out)
		else $error("pins not in normal mode under test reset");
endmodule // jbst_tap_props

// File: dv/jbst_tester.sv
`timescale 1ns/100ps
// board tester: tck stands low between frames, tdo sampled just before each rise
module jbst_tester (
	// tap pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire tdo,
	input wire tdo_oe_n
);
	// idle levels
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// n tck periods, vectors lsb first
	task automatic frame(input logic [63:0] tms_v, input logic [63:0] tdi_v, input int n,
		output logic [63:0] tdo_v);
		tdo_v = '0;
		for (int i = 0; i < n; i++) begin
			tms = tms_v[i];
			tdi = tdi_v[i];
			#62.5;
			// a released tdo reads as the inverse of its last value
			tdo_v[i] = tdo_oe_n ? ~tdo : tdo;
			tck = 1'b1;
			#62.5;
			tck = 1'b0;
		end
	endtask
	// five rises with tms high, then one low to idle
	task automatic reset_walk();
		logic [63:0] unused;
		frame(64'h1f, 64'h0, 6, unused);
	endtask
endmodule // jbst_tester

// File: dv/jtag_boundary_scan_tap_tb_top.sv
`timescale 1ns/100ps
// tester model walks the tap, a bit model predicts every scan
module jtag_boundary_scan_tap_tb_top;
	localparam logic [31:0] ID = {4'h1, 16'h1234, 11'h2aa, 1'b1}; // arbitrary id
	localparam int CL = 17; // chain length at default pin counts
	logic ref_clk, nrst, trst_n;
	logic [2:0] in_pad;
	logic [3:0] out_core, bd_pad_in, bd_core_out;
	logic [1:0] bd_core_oe_n;
	wire tck, tms, tdi, tdo, tdo_oe_n, out_pad_oe_n;
	wire [2:0] in_core;
	wire [3:0] out_pad, bd_pad_out, bd_pad_oe_n, bd_core_in;
	int err_total = 0;
	int checks = 0;
	// system clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	jbst_tap #(.ID_VER(ID[31:28]), .ID_PART(ID[27:12]), .ID_MFR(ID[11:1])) dut (.ref_clk, .nrst, .tck, .tms,
		.tdi, .trst_n, .tdo, .tdo_oe_n, .in_pad, .in_core, .out_core, .out_pad, .out_pad_oe_n, .bd_pad_in,
		.bd_core_out, .bd_core_oe_n, .bd_core_in, .bd_pad_out, .bd_pad_oe_n);
	jbst_tester jt (.tck, .tms, .tdi, .tdo, .tdo_oe_n);
	// compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// verdict
	task automatic summarize();
		$display("counts: checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// register of len bits captured cap, then n bits of d shifted through
	function automatic logic [63:0] model(int len, logic [63:0] cap, logic [63:0] d, int n);
		return ((cap & ((64'h1 << len) - 1)) | (d << len)) & ((64'h1 << n) - 1);
	endfunction
	// idle to shift-ir, five bits, back to idle
	task automatic ir_load(input logic [4:0] code);
		logic [63:0] o;
		jt.frame(64'h303, {55'h0, code, 4'h0}, 11, o);
		chk(o[8:4], 5'h01, "ir capture");
	endtask
	// idle to shift-dr, n bits, back to idle
	task automatic dr(input int n, input logic [63:0] d, output logic [63:0] q);
		logic [63:0] o;
		jt.frame(64'h1 | (64'h3 << (n + 2)), d << 3, n + 5, o);
		q = (o >> 3) & ((64'h1 << n) - 1);
	endtask
	// from reset or idle, read the id through a 40-bit scan
	task automatic check_id(input string name);
		logic [63:0] o, d, q;
		jt.frame(64'h0, 64'h0, 1, o);
		d = {$urandom, $urandom};
		dr(40, d, q);
		chk(q, model(32, ID, d, 40), "id read");
		$display("test %s done", name);
	endtask
	// main sequence
	initial begin
		logic [63:0] d, q, cap, cells;
		logic [3:0] oe_exp;
		int len;
		nrst = 1'b0;
		trst_n = 1'b1;
		{in_pad, out_core, bd_pad_in, bd_core_out, bd_core_oe_n} = 17'h0;
		void'($urandom(13070));
		repeat (12) @(posedge ref_clk);
		#1 nrst = 1'b1;
		repeat (20) @(posedge ref_clk);
		check_id("power-up");
		cells = '0;
		// every code: unlisted ones must act as bypass
		for (int c = 0; c < 32; c++) begin
			@(posedge ref_clk);
			#1 {in_pad, out_core, bd_pad_in, bd_core_out, bd_core_oe_n} = 17'($urandom);
			ir_load(c[4:0]);
			d = {$urandom, $urandom};
			dr(40, d, q);
			cap = {47'h0, bd_core_oe_n, bd_core_out, bd_pad_in, out_core, in_pad};
			len = (c < 2) ? CL : (c == 12) ? 32 : 1;
			chk(q, model(len, (c < 2) ? cap : (c == 12) ? ID : 64'h0, d, 40), "dr scan");
			if (c < 2)
				cells = d >> (40 - CL);
			chk(out_pad, (c == 0 || c == 4) ? cells[6:3] : out_core, "out pins");
			chk(bd_pad_out, (c == 0 || c == 4) ? cells[14:11] : bd_core_out, "bidir pins");
			chk(out_pad_oe_n, c == 5, "float");
			oe_exp = (c == 0 || c == 4) ? {{2{cells[16]}}, {2{cells[15]}}} : {{2{bd_core_oe_n[1]}}, {2{bd_core_oe_n[0]}}};
			chk(bd_pad_oe_n, (c == 5) ? 4'hf : oe_exp, "bidir enables");
			chk(bd_core_in, bd_pad_in, "bidir to core");
			chk(tdo_oe_n, 1'b1, "tdo released");
		end
		$display("test codes done");
		jt.reset_walk();
		check_id("tms reset");
		ir_load(5'h00); // extest, so the test reset has pins to hand back
		@(posedge ref_clk);
		#1 trst_n = 1'b0;
		repeat (8) @(posedge ref_clk);
		#1 trst_n = 1'b1;
		check_id("test reset");
		summarize();
	end
	// hang guard, about two and a half times the expected run
	initial begin
		#600000;
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		summarize();
	end
endmodule // jtag_boundary_scan_tap_tb_top
bind jbst_tap jbst_tap_props #(.N_IN(N_IN), .N_OUT(N_OUT), .N_BIDIR(N_BIDIR)) u_props (.ref_clk, .nrst, .tck,
	.trst_n, .tdo, .tdo_oe_n, .in_pad, .in_core, .out_core, .out_pad, .out_pad_oe_n, .bd_core_out, .bd_pad_out,
	.bd_pad_oe_n);
